// *** scb_bus_peer.sv ***
`timescale 1ns/1ps
// far-side target: acks every ninth bit and may stretch the clock low phase
module scb_bus_peer (
    input wire logic scl, input wire logic sda, input wire logic stretch,
    output logic scl_oe, output logic sda_oe
);
    int bits = 0;
    initial {scl_oe, sda_oe} = 2'b00;
    // a data edge while the clock is high marks a frame boundary
    always @(sda) if (scl === 1'b1) bits = 0;
    always @(posedge scl) bits++;
    // ack changes only while the clock is low, so no false frame is seen
    always @(negedge scl) begin
        sda_oe <= (bits % 9 == 8);
        if (stretch) begin
            scl_oe <= 1'b1;
            #200 scl_oe <= 1'b0;
        end
    end
endmodule

// *** scb_line_if.sv ***
`timescale 1ns/1ps
// synchronised bus view plus data-line drive path between engine and helpers
interface scb_line_if;
    logic scl;
    logic sda;
    logic start_seen;
    logic stop_seen;
    logic busy;
    logic sda_req;
    logic hold_en;
    logic sda_drive;

    modport mon (output scl, output sda, output start_seen, output stop_seen, output busy);
    modport hold (input sda_req, input hold_en, output sda_drive);
    modport eng (input scl, input sda, input start_seen, input stop_seen, input busy,
                 output sda_req, output hold_en, input sda_drive);
endinterface

// *** scb_line_mon.sv ***
`timescale 1ns/1ps
module scb_line_mon (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // raw pins, route 0 then route 1
    input wire logic scl_r0,
    input wire logic sda_r0,
    input wire logic scl_r1,
    input wire logic sda_r1,
    input wire logic route,
    // bus view
    scb_line_if.mon ln
);
    import scb_pkg::*;

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic scl_q;
        logic sda_q;
        logic busy;
    } scb_mon_t;

    scb_mon_t mon_reg;
    scb_mon_t mon_next;
    logic scl;
    logic sda;

    // route mux only looks at second stage flops
    assign scl = route ? mon_reg.s2[2] : mon_reg.s2[0];
    assign sda = route ? mon_reg.s2[3] : mon_reg.s2[1];

    // start and stop are data edges while the clock stays high
    always_comb begin
        mon_next = mon_reg;
        mon_next.s1 = {sda_r1, scl_r1, sda_r0, scl_r0};
        mon_next.s2 = mon_reg.s1;
        mon_next.scl_q = scl;
        mon_next.sda_q = sda;
        if (ln.start_seen) begin
            mon_next.busy = 1'b1;
        end else if (ln.stop_seen) begin
            mon_next.busy = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mon_reg <= '{s1: 4'hF, s2: 4'hF, scl_q: 1'b1, sda_q: 1'b1, busy: 1'b0};
        end else begin
            mon_reg <= mon_next;
        end
    end

    assign ln.scl = scl;
    assign ln.sda = sda;
    assign ln.start_seen = scl & mon_reg.scl_q & mon_reg.sda_q & ~sda;
    assign ln.stop_seen = scl & mon_reg.scl_q & ~mon_reg.sda_q & sda;
    assign ln.busy = mon_reg.busy;
endmodule

// *** scb_pkg.sv ***
package scb_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] SCB_CTL_ADDR = 8'hC0;
    localparam logic [7:0] SCB_STAT_ADDR = 8'hC4;
    localparam logic [7:0] SCB_DATA_ADDR = 8'hC8;
    localparam logic [7:0] SCB_ISTS_ADDR = 8'hCC;
    localparam logic [7:0] SCB_IMSK_ADDR = 8'hD0;

    // control field positions
    localparam int CTL_HOLD = 7;
    localparam int CTL_EN = 6;
    localparam int CTL_STA = 5;
    localparam int CTL_STO = 4;
    localparam int CTL_SI = 3;
    localparam int CTL_AA = 2;
    localparam int CTL_ROUTE = 0;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] CTL_WMASK = 8'hF5;

    // interrupt status and mask layout
    localparam int IRQ_XFER = 0;
    localparam int IRQ_STOP = 1;
    localparam int IRQ_BERR = 2;
    localparam int IRQ_W = 3;

    // ****************************************
    // status codes
    // ****************************************
    localparam logic [7:0] CODE_IDLE = 8'hF8;
    localparam logic [7:0] CODE_BERR = 8'h00;
    localparam logic [7:0] CODE_START = 8'h08;
    localparam logic [7:0] CODE_RSTART = 8'h10;
    localparam logic [7:0] CODE_AW_ACK = 8'h18;
    localparam logic [7:0] CODE_AW_NACK = 8'h20;
    localparam logic [7:0] CODE_TX_ACK = 8'h28;
    localparam logic [7:0] CODE_TX_NACK = 8'h30;
    localparam logic [7:0] CODE_ARB = 8'h38;
    localparam logic [7:0] CODE_AR_ACK = 8'h40;
    localparam logic [7:0] CODE_AR_NACK = 8'h48;
    localparam logic [7:0] CODE_RX_ACK = 8'h50;
    localparam logic [7:0] CODE_RX_NACK = 8'h58;

    // ****************************************
    // timing
    // ****************************************
    localparam int HOLD_EXT_CYCLES = 8;
    localparam int QTR_DEFAULT = 10;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_WAIT = 3'b001,
        S_START = 3'b010,
        S_HOLD = 3'b011,
        S_BIT = 3'b100,
        S_STOP = 3'b101,
        S_ERR = 3'b110
    } scb_state_t;

endpackage

// *** scb_properties.sv ***
`timescale 1ns/1ps
// watches the register port and the pin enables of the control block
module scb_properties (
    // clock, reset and apb
    input wire logic clk, input wire logic reset, input wire logic psel, input wire logic penable,
    input wire logic pwrite, input wire logic [7:0] paddr, input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata, input wire logic pready, input wire logic pslverr, input wire logic irq,
    // pin enables
    input wire logic serial_clock_pin_r0_oe, input wire logic serial_data_pin_r0_oe,
    input wire logic serial_clock_pin_r1_oe, input wire logic serial_data_pin_r1_oe
);
    logic [2:0] sh_reg;
    logic [1:0] dly_reg;
    logic wr;
    assign wr = psel && penable && pwrite;
    // shadow of software-only bits: hold extend, route, any mask; delayed copy covers register lag
    always_ff @(posedge clk) begin
        if (reset) begin
            sh_reg <= 3'h0;
            dly_reg <= 2'h0;
        end else begin
            if (wr && paddr == 8'hC0) sh_reg[2:1] <= {pwdata[7], pwdata[0]};
            if (wr && paddr == 8'hD0) sh_reg[0] <= |pwdata[2:0];
            dly_reg <= sh_reg[1:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_scl_fall; $rose(serial_clock_pin_r0_oe) && sh_reg[2]; endsequence
    sequence s_sda_quiet; $stable(serial_data_pin_r0_oe) [*8]; endsequence
    a_hold_extend: assert property (s_scl_fall |-> s_sda_quiet)
        else $error("data moved inside hold window");
    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("wait state seen");
    a_err_phase: assert property (!(psel && penable) |-> !pslverr)
        else $error("error outside access phase");
    a_unmapped_err: assert property (psel && penable && paddr == 8'hD4 |-> pslverr)
        else $error("unmapped access not refused");
    a_bit1_zero: assert property (psel && penable && !pwrite && paddr == 8'hC0 |-> prdata[1] == 1'b0)
        else $error("control bit 1 reads one");
    a_route_zero: assert property (!sh_reg[1] && !dly_reg[1] |-> !serial_clock_pin_r1_oe && !serial_data_pin_r1_oe)
        else $error("unselected pins driven");
    a_route_one: assert property (sh_reg[1] && dly_reg[1] |-> !serial_clock_pin_r0_oe && !serial_data_pin_r0_oe)
        else $error("unselected pins driven");
    a_irq_masked: assert property (!sh_reg[0] && !dly_reg[0] |-> !irq)
        else $error("masked interrupt raised");
endmodule

// *** scb_sda_hold.sv ***
`timescale 1ns/1ps
module scb_sda_hold (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // drive path
    scb_line_if.hold ln
);
    import scb_pkg::*;

    typedef struct packed {
        logic [3:0] cnt;
        logic out;
    } scb_hold_t;

    scb_hold_t hold_reg;
    scb_hold_t hold_next;

    // a pending change waits out the extension, a steady request resets the count
    always_comb begin
        hold_next = hold_reg;
        if (ln.sda_req == hold_reg.out) begin
            hold_next.cnt = 4'h0;
        end else if (!ln.hold_en || hold_reg.cnt == 4'(HOLD_EXT_CYCLES)) begin
            hold_next.out = ln.sda_req;
            hold_next.cnt = 4'h0;
        end else begin
            hold_next.cnt = hold_reg.cnt + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            hold_reg <= '{cnt: 4'h0, out: 1'b0};
        end else begin
            hold_reg <= hold_next;
        end
    end

    assign ln.sda_drive = hold_reg.out;
endmodule

// *** scb_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t mismatch %h != %h", $time, a, b); end end
module scb_tb_top;
    import scb_pkg::*;
    logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stretch = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q, v;
    logic pready, irq, c0, d0, c1, d1, pc, pd;
    int errors = 0, n_compared = 0, k, j;
    // open-drain lines: any pull wins, else the pull-up
    wire scl = !(c0 | pc);
    wire sda = !(d0 | pd);
    always #2 clk = ~clk;
    scb_top #(.QTR_CYCLES(10)) i_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(), .irq(irq),
        .serial_clock_pin_r0_i(scl), .serial_clock_pin_r0_o(), .serial_clock_pin_r0_oe(c0),
        .serial_data_pin_r0_i(sda), .serial_data_pin_r0_o(), .serial_data_pin_r0_oe(d0),
        .serial_clock_pin_r1_i(!c1), .serial_clock_pin_r1_o(), .serial_clock_pin_r1_oe(c1),
        .serial_data_pin_r1_i(!d1), .serial_data_pin_r1_o(), .serial_data_pin_r1_oe(d1));
    scb_bus_peer i_peer (.scl(scl), .sda(sda), .stretch(stretch), .scl_oe(pc), .sda_oe(pd));
    task automatic final_report;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic tmo(input bit t);
        if (t) begin
            errors++;
            $display("[ERR] %0t wait timed out", $time);
            final_report();
        end
    endtask
    // one apb transfer; read data is taken into q at the pready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k == 0 || (pready !== 1'b1 && k < 20); k++) @(posedge clk);
        q = prdata;
        {psel, penable} <= 2'b00;
        tmo(k >= 20);
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask
    // wait for the event, check its code, then walk the mask and the sticky bit
    task automatic wirq(input logic [7:0] code);
        for (j = 0; j < 3000 && irq !== 1'b1; j++) @(posedge clk);
        tmo(j >= 3000);
        rd(SCB_STAT_ADDR, {24'h0, code});
        apb(1'b1, SCB_IMSK_ADDR, 32'h0);
        `CHK(irq, 1'b0)
        apb(1'b1, SCB_IMSK_ADDR, 32'h1);
        `CHK(irq, 1'b1)
        apb(1'b1, SCB_ISTS_ADDR, 32'h1);
        `CHK(irq, 1'b0)
    endtask
    initial begin
        v = $urandom(32'h0079);
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(SCB_CTL_ADDR, 32'h0);
        rd(SCB_STAT_ADDR, 32'hF8);
        $display("reset values done");
        for (int i = 0; i < 6; i++) begin
            v = $urandom & 32'h87;
            apb(1'b1, SCB_CTL_ADDR, v);
            rd(SCB_CTL_ADDR, v & 32'h85);
        end
        rd(8'hD4, 32'h0);
        $display("control bits done");
        apb(1'b1, SCB_IMSK_ADDR, 32'h1);
        apb(1'b1, SCB_CTL_ADDR, 32'hC4);
        apb(1'b1, SCB_CTL_ADDR, 32'hE4);
        wirq(CODE_START);
        rd(SCB_CTL_ADDR, 32'hEC);
        repeat (80) @(posedge clk);
        `CHK(scl, 1'b0)
        apb(1'b1, SCB_DATA_ADDR, $urandom & 32'hFE);
        apb(1'b1, SCB_CTL_ADDR, 32'hC4);
        wirq(CODE_AW_ACK);
        stretch <= 1'b1;
        apb(1'b1, SCB_DATA_ADDR, $urandom & 32'hFF);
        apb(1'b1, SCB_CTL_ADDR, 32'hC4);
        wirq(CODE_TX_ACK);
        stretch <= 1'b0;
        apb(1'b1, SCB_CTL_ADDR, 32'hE4);
        wirq(CODE_RSTART);
        apb(1'b1, SCB_CTL_ADDR, 32'hF4);
        wirq(CODE_START);
        rd(SCB_CTL_ADDR, 32'hEC);
        apb(1'b1, SCB_CTL_ADDR, 32'hD4);
        q = 32'h10;
        for (j = 0; j < 40 && q[4] !== 1'b0; j++) apb(1'b0, SCB_CTL_ADDR, 32'h0);
        tmo(j >= 40);
        rd(SCB_CTL_ADDR, 32'hC4);
        rd(SCB_STAT_ADDR, 32'hF8);
        `CHK({scl, sda, irq}, 3'b110)
        $display("master transfer done");
        final_report();
    end
endmodule
bind scb_top scb_properties i_chk (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .serial_clock_pin_r0_oe(serial_clock_pin_r0_oe), .serial_data_pin_r0_oe(serial_data_pin_r0_oe),
    .serial_clock_pin_r1_oe(serial_clock_pin_r1_oe), .serial_data_pin_r1_oe(serial_data_pin_r1_oe));

// *** scb_top.sv ***
// Chosen here: register access over APB.
`timescale 1ns/1ps
module scb_top #(
    parameter int QTR_CYCLES = scb_pkg::QTR_DEFAULT
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt
    output logic irq,
    // serial clock pin, route 0
    input wire logic serial_clock_pin_r0_i,
    output logic serial_clock_pin_r0_o,
    output logic serial_clock_pin_r0_oe,
    // serial data pin, route 0
    input wire logic serial_data_pin_r0_i,
    output logic serial_data_pin_r0_o,
    output logic serial_data_pin_r0_oe,
    // serial clock pin, route 1
    input wire logic serial_clock_pin_r1_i,
    output logic serial_clock_pin_r1_o,
    output logic serial_clock_pin_r1_oe,
    // serial data pin, route 1
    input wire logic serial_data_pin_r1_i,
    output logic serial_data_pin_r1_o,
    output logic serial_data_pin_r1_oe
);
    import scb_pkg::*;

    // ****************************************
    // parameter check
    // ****************************************
    // the quarter bit must outlast the data hold extension
    if (QTR_CYCLES < HOLD_EXT_CYCLES + 2 || QTR_CYCLES > 65535) begin : g_bad_qtr
        $error("QTR_CYCLES out of range");
    end

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        scb_state_t state;
        logic [7:0] ctl;
        logic [7:0] code;
        logic [7:0] data;
        logic [3:0] bitn;
        logic [1:0] phase;
        logic [15:0] qcnt;
        logic master;
        logic moved;
        logic first;
        logic rd;
        logic rstart;
        logic scl_oe;
        logic sda_req;
        logic [IRQ_W-1:0] ists;
        logic [IRQ_W-1:0] imsk;
        logic [31:0] prdata;
    } scb_main_t;

    scb_main_t st_reg;
    scb_main_t st_next;
    scb_line_if ln ();

    logic qtick;
    logic adv;
    logic tx;
    logic si_set;
    logic berr;
    logic wr_en;
    logic hit;
    logic [31:0] rd_mux;
    logic [7:0] shifted;

    scb_line_mon u_mon (
        .clk(clk),
        .reset(reset),
        .scl_r0(serial_clock_pin_r0_i),
        .sda_r0(serial_data_pin_r0_i),
        .scl_r1(serial_clock_pin_r1_i),
        .sda_r1(serial_data_pin_r1_i),
        .route(st_reg.ctl[CTL_ROUTE]),
        .ln(ln.mon)
    );

    scb_sda_hold u_hold (
        .clk(clk),
        .reset(reset),
        .ln(ln.hold)
    );

    assign ln.sda_req = st_reg.sda_req;
    assign ln.hold_en = st_reg.ctl[CTL_HOLD];

    // ****************************************
    // bus slave decode
    // ****************************************
    // zero wait states: read data is captured in the setup cycle
    assign wr_en = psel & penable & pwrite;
    assign hit = (paddr == SCB_CTL_ADDR) | (paddr == SCB_STAT_ADDR) | (paddr == SCB_DATA_ADDR)
                 | (paddr == SCB_ISTS_ADDR) | (paddr == SCB_IMSK_ADDR);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign prdata = st_reg.prdata;

    // read mux, unused control bit 1 is never stored so it reads zero
    always_comb begin
        rd_mux = 32'h0;
        case (paddr)
            SCB_CTL_ADDR: rd_mux = {24'h0, st_reg.ctl};
            SCB_STAT_ADDR: rd_mux = {24'h0, st_reg.code[7:3], 3'b000};
            SCB_DATA_ADDR: rd_mux = {24'h0, st_reg.data};
            SCB_ISTS_ADDR: rd_mux = {29'h0, st_reg.ists};
            SCB_IMSK_ADDR: rd_mux = {29'h0, st_reg.imsk};
            default: rd_mux = 32'h0;
        endcase
    end

    // ****************************************
    // protocol engine
    // ****************************************
    assign qtick = (st_reg.qcnt == 16'h0);
    // the high quarter only advances once the line is really high (stretching)
    assign adv = qtick & ((st_reg.phase != 2'd2) | ln.scl);
    assign tx = st_reg.first | ~st_reg.rd;
    assign shifted = {st_reg.data[6:0], ln.sda};

    always_comb begin
        st_next = st_reg;
        si_set = 1'b0;
        berr = 1'b0;
        st_next.qcnt = qtick ? 16'(QTR_CYCLES - 1) : st_reg.qcnt - 16'h1;

        // halt request drops once a stop is seen on the bus
        if (ln.stop_seen) begin
            st_next.ctl[CTL_STO] = 1'b0;
        end

        if (!st_reg.ctl[CTL_EN]) begin
            // disabled: released lines, idle code, no flag except the bus stop flag
            st_next.state = S_IDLE;
            st_next.scl_oe = 1'b0;
            st_next.sda_req = 1'b0;
            st_next.master = 1'b0;
            st_next.code = CODE_IDLE;
        end else begin
            case (st_reg.state)
                S_IDLE: begin
                    st_next.scl_oe = 1'b0;
                    st_next.sda_req = 1'b0;
                    st_next.master = 1'b0;
                    if (st_reg.ctl[CTL_STA] && !st_reg.ctl[CTL_SI]) begin
                        st_next.rstart = 1'b0;
                        st_next.phase = 2'd0;
                        st_next.state = ln.busy ? S_WAIT : S_START;
                    end
                end
                S_WAIT: begin
                    // another master holds the bus until its stop
                    if (!st_reg.ctl[CTL_STA]) begin
                        st_next.state = S_IDLE;
                    end else if (!ln.busy) begin
                        st_next.phase = 2'd0;
                        st_next.state = S_START;
                    end
                end
                S_START: begin
                    // same sequence serves both starts; the clock waits for the delayed data line
                    if (adv && (st_reg.phase != 2'd0 || ln.sda_drive == st_reg.sda_req)) begin
                        st_next.phase = st_reg.phase + 2'd1;
                        case (st_reg.phase)
                            2'd0: st_next.scl_oe = 1'b0;
                            2'd2: st_next.sda_req = 1'b1;
                            2'd3: begin
                                st_next.scl_oe = 1'b1;
                                st_next.master = 1'b1;
                                st_next.first = 1'b1;
                                st_next.moved = 1'b0;
                                st_next.code = st_reg.rstart ? CODE_RSTART : CODE_START;
                                si_set = 1'b1;
                                st_next.state = S_HOLD;
                            end
                            default: st_next.phase = st_reg.phase + 2'd1;
                        endcase
                    end
                end
                S_HOLD: begin
                    st_next.scl_oe = st_reg.master;
                    if (!st_reg.ctl[CTL_SI]) begin
                        st_next.phase = 2'd0;
                        if (!st_reg.master) begin
                            st_next.state = S_IDLE;
                        end else if (st_reg.ctl[CTL_STO]) begin
                            // with begin request still set the idle state starts again
                            st_next.sda_req = 1'b1;
                            st_next.state = S_STOP;
                        end else if (st_reg.ctl[CTL_STA] && st_reg.moved) begin
                            st_next.sda_req = 1'b0;
                            st_next.rstart = 1'b1;
                            st_next.state = S_START;
                        end else begin
                            st_next.bitn = 4'h0;
                            st_next.sda_req = tx & ~st_reg.data[7];
                            st_next.state = S_BIT;
                        end
                    end
                end
                S_BIT: begin
                    if (ln.start_seen || ln.stop_seen) begin
                        // a frame edge inside a byte is a bus error
                        berr = 1'b1;
                        si_set = 1'b1;
                        st_next.code = CODE_BERR;
                        st_next.master = 1'b0;
                        st_next.scl_oe = 1'b0;
                        st_next.sda_req = 1'b0;
                        st_next.state = S_ERR;
                    end else if (adv) begin
                        st_next.phase = st_reg.phase + 2'd1;
                        if (st_reg.phase == 2'd1) begin
                            st_next.scl_oe = 1'b0;
                        end else if (st_reg.phase == 2'd3) begin
                            st_next.scl_oe = 1'b1;
                            st_next.bitn = st_reg.bitn + 4'h1;
                            if (st_reg.bitn != 4'd8) begin
                                st_next.data = shifted;
                                if (tx && !st_reg.sda_req && !ln.sda) begin
                                    // lost arbitration: release both lines at once
                                    st_next.code = CODE_ARB;
                                    st_next.master = 1'b0;
                                    st_next.scl_oe = 1'b0;
                                    st_next.sda_req = 1'b0;
                                    si_set = 1'b1;
                                    st_next.state = S_HOLD;
                                end else if (st_reg.bitn == 4'd7) begin
                                    st_next.sda_req = ~tx & st_reg.ctl[CTL_AA];
                                end else begin
                                    st_next.sda_req = tx & ~shifted[7];
                                end
                            end else begin
                                // acknowledge slot done: report and park
                                st_next.sda_req = 1'b0;
                                st_next.moved = 1'b1;
                                st_next.first = 1'b0;
                                if (st_reg.first) begin
                                    st_next.rd = st_reg.data[0];
                                    if (st_reg.data[0]) begin
                                        st_next.code = ln.sda ? CODE_AR_NACK : CODE_AR_ACK;
                                    end else begin
                                        st_next.code = ln.sda ? CODE_AW_NACK : CODE_AW_ACK;
                                    end
                                end else if (st_reg.rd) begin
                                    st_next.code = st_reg.ctl[CTL_AA] ? CODE_RX_ACK : CODE_RX_NACK;
                                end else begin
                                    st_next.code = ln.sda ? CODE_TX_NACK : CODE_TX_ACK;
                                end
                                si_set = 1'b1;
                                st_next.state = S_HOLD;
                            end
                        end
                    end
                end
                S_STOP: begin
                    if (adv && (st_reg.phase != 2'd0 || ln.sda_drive == st_reg.sda_req)) begin
                        st_next.phase = st_reg.phase + 2'd1;
                        case (st_reg.phase)
                            2'd0: st_next.scl_oe = 1'b0;
                            2'd2: st_next.sda_req = 1'b0;
                            2'd3: begin
                                st_next.master = 1'b0;
                                st_next.code = CODE_IDLE;
                                st_next.state = S_IDLE;
                            end
                            default: st_next.phase = st_reg.phase + 2'd1;
                        endcase
                    end
                end
                S_ERR: begin
                    // recovery leaves the lines alone, no stop goes out
                    st_next.scl_oe = 1'b0;
                    st_next.sda_req = 1'b0;
                    if (st_reg.ctl[CTL_STO]) begin
                        st_next.ctl[CTL_STO] = 1'b0;
                        st_next.code = CODE_IDLE;
                        st_next.state = S_IDLE;
                    end
                end
                default: st_next.state = S_IDLE;
            endcase
        end

        // software access after hardware clears, so a software set wins
        if (psel && !penable && !pwrite) begin
            st_next.prdata = rd_mux;
        end
        if (wr_en) begin
            case (paddr)
                SCB_CTL_ADDR: begin
                    st_next.ctl = pwdata[7:0] & CTL_WMASK;
                    st_next.ctl[CTL_SI] = st_reg.ctl[CTL_SI] & pwdata[CTL_SI];
                end
                SCB_DATA_ADDR: st_next.data = pwdata[7:0];
                SCB_ISTS_ADDR: st_next.ists = st_reg.ists & ~pwdata[IRQ_W-1:0];
                SCB_IMSK_ADDR: st_next.imsk = pwdata[IRQ_W-1:0];
                default: st_next.imsk = st_reg.imsk;
            endcase
        end

        // hardware sets win over a clear in the same cycle
        if (si_set) begin
            st_next.ctl[CTL_SI] = 1'b1;
            st_next.ists[IRQ_XFER] = 1'b1;
        end
        if (ln.stop_seen) begin
            st_next.ists[IRQ_STOP] = 1'b1;
        end
        if (berr) begin
            st_next.ists[IRQ_BERR] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_reg <= '{state: S_IDLE, ctl: CTL_RESET, code: CODE_IDLE, data: 8'h00,
                        bitn: 4'h0, phase: 2'd0, qcnt: 16'h0, master: 1'b0, moved: 1'b0,
                        first: 1'b0, rd: 1'b0, rstart: 1'b0, scl_oe: 1'b0, sda_req: 1'b0,
                        ists: 3'h0, imsk: 3'h0, prdata: 32'h0};
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // pins and interrupt
    // ****************************************
    // open drain: enable pulls low, the route bit picks the pin pair at once
    assign serial_clock_pin_r0_o = 1'b0;
    assign serial_data_pin_r0_o = 1'b0;
    assign serial_clock_pin_r1_o = 1'b0;
    assign serial_data_pin_r1_o = 1'b0;
    assign serial_clock_pin_r0_oe = st_reg.scl_oe & ~st_reg.ctl[CTL_ROUTE];
    assign serial_data_pin_r0_oe = ln.sda_drive & ~st_reg.ctl[CTL_ROUTE];
    assign serial_clock_pin_r1_oe = st_reg.scl_oe & st_reg.ctl[CTL_ROUTE];
    assign serial_data_pin_r1_oe = ln.sda_drive & st_reg.ctl[CTL_ROUTE];
    assign irq = |(st_reg.ists & st_reg.imsk);
endmodule
